// ==== core/uifl_core.sv ====
// interrupt identification and line format control with an axi4-lite slave
// What this block does
// - rank pending causes into six levels
// - report only highest cause until serviced
// - line status is level one, code 000110
// - rx data 000100, timeout 001100, level two
// - bits 3:1 encode levels 1-3; thr 000010
// - modem change level four, all zeros
// - xoff/special level five, code 010000
// - cts/rts change level six, code 100000
// - bits 7:6 ones in fifo mode
// - bits 5:4 only with enhanced enable
// - bit 4 holds from xoff until xon
// - bit 0 low while any enabled cause pending, levels 5-6 also need enhanced enable
// - line bit 7 selects divisor latch space
// - line bit 6 forces transmit low
// - line bits 5:3 select parity
// - line bit 2 selects stop length
// - line bits 1:0 select word length
module uifl_core
    import uifl_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // cause events from the uart, one-cycle pulses on aclk
    input wire logic [UIFL_NCAUSE-1:0] cause_event,
    input wire logic xon_received,
    // serial side
    input wire logic tx_serial_in,
    output logic tx_serial_out,
    output logic divisor_access,
    // interrupt
    output logic irq
);
    // register state
    logic [7:0] line_format_control; // line format
    logic [UIFL_NCAUSE-1:0] pending; // sticky cause bits
    logic [UIFL_NCAUSE-1:0] mask; // cause enables
    logic [1:0] config_bits; // fifo and enhanced enables
    logic xoff_hold; // stays set from xoff until xon
    logic [UIFL_NCAUSE-1:0] active; // enabled pending causes
    logic [7:0] ident; // identification value
    logic [2:0] word_bits; // word length minus five
    logic [1:0] stop_half; // stop length in half bits
    uifl_par_t par_mode; // decoded parity
    // bus handshake state
    logic aw_held, w_held; // captured halves of a write
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write, do_read;
    logic [UIFL_NCAUSE-1:0] svc; // service pulse on write
    logic [UIFL_NCAUSE-1:0] clr; // causes cleared by software this cycle
    logic [5:0] hold_bit; // xoff hold as it shows in bits 5 to 0

    assign active = pending & mask;
    // the xoff hold overlays bit 4 on whatever code is reported, so checks add it in
    assign hold_bit = {1'b0, config_bits[UIFL_CFG_ENH] & xoff_hold, 4'h0};

    // priority encoder of the identification value
    always_comb begin
        ident = {2'h0, UIFL_ID_NONE};
        if (active[UIFL_C_LINE]) begin
            ident[5:0] = UIFL_ID_LINE;
        end else if (active[UIFL_C_RXDA]) begin
            ident[5:0] = UIFL_ID_RXDA;
        end else if (active[UIFL_C_RXTO]) begin
            ident[5:0] = UIFL_ID_RXTO;
        end else if (active[UIFL_C_THRE]) begin
            ident[5:0] = UIFL_ID_THRE;
        end else if (active[UIFL_C_MODM]) begin
            ident[5:0] = UIFL_ID_MODM;
        end else if (config_bits[UIFL_CFG_ENH] && active[UIFL_C_XOFF]) begin
            ident[5:0] = UIFL_ID_XOFF;
        end else if (config_bits[UIFL_CFG_ENH] && active[UIFL_C_FLOW]) begin
            ident[5:0] = UIFL_ID_FLOW;
        end
        // bit 4 stays up from xoff to xon, even under a higher cause
        if (config_bits[UIFL_CFG_ENH] && xoff_hold) begin
            ident[4] = 1'b1;
        end
        ident[7:6] = {2{config_bits[UIFL_CFG_FIFO]}};
    end

    // line format decode
    always_comb begin
        word_bits = {1'b0, line_format_control[1:0]};
        if (!line_format_control[UIFL_LF_STOP]) begin
            stop_half = 2'h2;
        end else if (line_format_control[1:0] == 2'h0) begin
            stop_half = 2'h3;
        end else begin
            stop_half = 2'h0; // two stops, encoded as zero
        end
        if (!line_format_control[3]) begin
            par_mode = UIFL_PM_NONE;
        end else begin
            unique case (line_format_control[5:3])
                UIFL_PAR_EVEN: par_mode = UIFL_PM_EVEN;
                UIFL_PAR_ONE: par_mode = UIFL_PM_ONE;
                UIFL_PAR_ZERO: par_mode = UIFL_PM_ZERO;
                default: par_mode = UIFL_PM_ODD;
            endcase
        end
    end

    // write address and data capture, any order
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // ready flags registered
    // each ready drops the cycle after its handshake so a half is taken once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    // write response
    // any word beyond the status register answers slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= UIFL_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr[7:2] > UIFL_ADDR_STATUS[7:2]) ? UIFL_RESP_SLVERR : UIFL_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // register writes
    assign svc = (do_write && aw_addr[7:2] == UIFL_ADDR_SERVICE[7:2] && w_strb[0])
        ? w_data[UIFL_NCAUSE-1:0] : '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_format_control <= UIFL_LF_RESET;
            mask <= '0;
            config_bits <= 2'h0;
        end else if (do_write && w_strb[0]) begin
            if (aw_addr[7:2] == UIFL_ADDR_LINE[7:2]) begin
                line_format_control <= w_data[7:0];
            end
            if (aw_addr[7:2] == UIFL_ADDR_MASK[7:2]) begin
                mask <= w_data[UIFL_NCAUSE-1:0];
            end
            if (aw_addr[7:2] == UIFL_ADDR_CONFIG[7:2]) begin
                config_bits <= w_data[1:0];
            end
        end
    end

    // causes cleared this cycle by service or write one to clear
    always_comb begin
        clr = svc;
        if (do_write && w_strb[0] && aw_addr[7:2] == UIFL_ADDR_EVENTS[7:2]) begin
            clr = clr | w_data[UIFL_NCAUSE-1:0]; // write one to clear
        end
    end

    // sticky causes, set wins over clear and service
    // so an event landing in the clear cycle is never lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending <= '0;
        end else begin
            pending <= (pending & ~clr) | cause_event;
        end
    end

    // xoff flag held until xon
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xoff_hold <= 1'b0;
        end else if (cause_event[UIFL_C_XOFF]) begin
            xoff_hold <= 1'b1;
        end else if (xon_received) begin
            xoff_hold <= 1'b0;
        end
    end

    // read channel
    // read data samples ident at the accept edge, so it shows causes up to that edge
    assign do_read = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= UIFL_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !do_read;
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= UIFL_RESP_OKAY;
                unique case (s_axi_araddr[7:2])
                    UIFL_ADDR_IDENT[7:2]: s_axi_rdata <= {24'h0, ident};
                    UIFL_ADDR_LINE[7:2]: s_axi_rdata <= {24'h0, line_format_control};
                    UIFL_ADDR_EVENTS[7:2]: s_axi_rdata <= {25'h0, pending};
                    UIFL_ADDR_MASK[7:2]: s_axi_rdata <= {25'h0, mask};
                    UIFL_ADDR_CONFIG[7:2]: s_axi_rdata <= {30'h0, config_bits};
                    UIFL_ADDR_SERVICE[7:2]: s_axi_rdata <= 32'h0000_0000;
                    UIFL_ADDR_STATUS[7:2]: s_axi_rdata <= {23'h0, xoff_hold, par_mode, stop_half, word_bits};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= UIFL_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // serial and interrupt outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_serial_out <= 1'b1;
            divisor_access <= 1'b0;
            irq <= 1'b0;
        end else begin
            tx_serial_out <= tx_serial_in && !line_format_control[UIFL_LF_BRK];
            divisor_access <= line_format_control[UIFL_LF_DLAB];
            irq <= |active;
        end
    end

    // checks
    AST_BREAK: assert property (@(posedge aclk) disable iff (!aresetn)
        line_format_control[UIFL_LF_BRK] |=> !tx_serial_out)
        else $error("break not forcing transmit low");
    AST_DLAB: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 divisor_access == $past(line_format_control[UIFL_LF_DLAB]))
        else $error("divisor access wrong");
    AST_TOP: assert property (@(posedge aclk) disable iff (!aresetn)
        active[UIFL_C_LINE] |-> ident[5:0] == (UIFL_ID_LINE | hold_bit))
        else $error("line status not top");
    AST_NONE: assert property (@(posedge aclk) disable iff (!aresetn)
        (active == '0) |-> ident[0])
        else $error("bit zero low with nothing pending");
    AST_PEND: assert property (@(posedge aclk) disable iff (!aresetn)
        (|active[UIFL_C_MODM:0]) |-> !ident[0])
        else $error("bit zero high while pending");
    AST_FIFO: assert property (@(posedge aclk) disable iff (!aresetn)
        do_read && s_axi_araddr[7:2] == UIFL_ADDR_IDENT[7:2]
            |=> s_axi_rdata[7:6] == {2{$past(config_bits[UIFL_CFG_FIFO])}})
        else $error("fifo bits wrong");
    AST_ENH: assert property (@(posedge aclk) disable iff (!aresetn)
        !config_bits[UIFL_CFG_ENH] |-> ident[5:4] == 2'h0)
        else $error("enhanced bits without enable");
    AST_SVC: assert property (@(posedge aclk) disable iff (!aresetn)
        svc[UIFL_C_THRE] && !cause_event[UIFL_C_THRE] |=> !pending[UIFL_C_THRE])
        else $error("serviced cause not dropped");
    AST_XOFF: assert property (@(posedge aclk) disable iff (!aresetn)
        cause_event[UIFL_C_XOFF] |=> xoff_hold)
        else $error("xoff flag not set");

    // code for each level when it is the highest enabled cause
    AST_RXDA: assert property (@(posedge aclk) disable iff (!aresetn)
        active[UIFL_C_RXDA] && !active[UIFL_C_LINE] |-> ident[5:0] == (UIFL_ID_RXDA | hold_bit))
        else $error("data available code wrong");
    AST_RXTO: assert property (@(posedge aclk) disable iff (!aresetn)
        active[UIFL_C_RXTO] && ~|active[UIFL_C_RXDA:0] |-> ident[5:0] == (UIFL_ID_RXTO | hold_bit))
        else $error("time-out code wrong");
    AST_THRE: assert property (@(posedge aclk) disable iff (!aresetn)
        active[UIFL_C_THRE] && ~|active[UIFL_C_RXTO:0] |-> ident[5:0] == (UIFL_ID_THRE | hold_bit))
        else $error("holding empty code wrong");
    AST_MODM: assert property (@(posedge aclk) disable iff (!aresetn)
        active[UIFL_C_MODM] && ~|active[UIFL_C_THRE:0] |-> ident[5:0] == (UIFL_ID_MODM | hold_bit))
        else $error("modem code wrong");
    AST_XCODE: assert property (@(posedge aclk) disable iff (!aresetn)
        config_bits[UIFL_CFG_ENH] && active[UIFL_C_XOFF] && ~|active[UIFL_C_MODM:0]
            |-> ident[5:0] == (UIFL_ID_XOFF | hold_bit))
        else $error("xoff code wrong");
    AST_FLOWC: assert property (@(posedge aclk) disable iff (!aresetn)
        config_bits[UIFL_CFG_ENH] && active[UIFL_C_FLOW] && ~|active[UIFL_C_XOFF:0]
            |-> ident[5:0] == (UIFL_ID_FLOW | hold_bit))
        else $error("flow control code wrong");

    // xoff hold release and set-wins causes
    AST_XON: assert property (@(posedge aclk) disable iff (!aresetn)
        xon_received && !cause_event[UIFL_C_XOFF] |=> !xoff_hold)
        else $error("xoff hold not released by xon");
    AST_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        (|cause_event) |=> (pending & $past(cause_event)) == $past(cause_event))
        else $error("cause event lost");

    // break release, parity and status read path
    AST_TXPASS: assert property (@(posedge aclk) disable iff (!aresetn)
        !line_format_control[UIFL_LF_BRK] |=> tx_serial_out == $past(tx_serial_in))
        else $error("transmit not passed through without break");
    AST_PAR1: assert property (@(posedge aclk) disable iff (!aresetn)
        line_format_control[5:3] == UIFL_PAR_ONE |-> par_mode == UIFL_PM_ONE)
        else $error("forced one parity not decoded");
    AST_STAT: assert property (@(posedge aclk) disable iff (!aresetn)
        do_read && s_axi_araddr[7:2] == UIFL_ADDR_STATUS[7:2]
            |=> s_axi_rdata[2:0] == {1'b0, $past(line_format_control[1:0])})
        else $error("word length decode wrong");
endmodule

// ==== core/uifl_pkg.sv ====
// constants for the interrupt identification and line format block
package uifl_pkg;
    // register byte addresses
    localparam logic [7:0] UIFL_ADDR_IDENT   = 8'h00; // interrupt_identification, read only
    localparam logic [7:0] UIFL_ADDR_LINE    = 8'h04; // line_format_control
    localparam logic [7:0] UIFL_ADDR_EVENTS  = 8'h08; // cause events, sticky, write one to clear
    localparam logic [7:0] UIFL_ADDR_MASK    = 8'h0c; // cause enables
    localparam logic [7:0] UIFL_ADDR_CONFIG  = 8'h10; // fifo enable, enhanced enable
    localparam logic [7:0] UIFL_ADDR_SERVICE = 8'h14; // write one to service a cause
    localparam logic [7:0] UIFL_ADDR_STATUS  = 8'h18; // line format decode and flags
    // cause bit positions in events, mask and service
    localparam int UIFL_C_LINE = 0; // receiver line status, level 1
    localparam int UIFL_C_RXDA = 1; // receive data available, level 2
    localparam int UIFL_C_RXTO = 2; // receive time-out, level 2
    localparam int UIFL_C_THRE = 3; // transmit holding empty, level 3
    localparam int UIFL_C_MODM = 4; // modem status change, level 4
    localparam int UIFL_C_XOFF = 5; // xoff or special character, level 5
    localparam int UIFL_C_FLOW = 6; // cts or rts change, level 6
    localparam int UIFL_NCAUSE = 7;
    localparam int UIFL_CFG_FIFO = 0; // fifo mode bit
    localparam int UIFL_CFG_ENH = 1;  // enhanced feature enable bit
    // identification codes, bits 5 to 0
    localparam logic [5:0] UIFL_ID_NONE = 6'h01;
    localparam logic [5:0] UIFL_ID_LINE = 6'h06;
    localparam logic [5:0] UIFL_ID_RXDA = 6'h04;
    localparam logic [5:0] UIFL_ID_RXTO = 6'h0c;
    localparam logic [5:0] UIFL_ID_THRE = 6'h02;
    localparam logic [5:0] UIFL_ID_MODM = 6'h00;
    localparam logic [5:0] UIFL_ID_XOFF = 6'h10;
    localparam logic [5:0] UIFL_ID_FLOW = 6'h20;
    // line format control fields
    localparam int UIFL_LF_DLAB = 7;
    localparam int UIFL_LF_BRK = 6;
    localparam int UIFL_LF_STOP = 2;
    localparam logic [7:0] UIFL_LF_RESET = 8'h00;
    // parity codes, bits 5 to 3
    localparam logic [2:0] UIFL_PAR_ODD = 3'h1;
    localparam logic [2:0] UIFL_PAR_EVEN = 3'h3;
    localparam logic [2:0] UIFL_PAR_ONE = 3'h5;
    localparam logic [2:0] UIFL_PAR_ZERO = 3'h7;
    // parity mode encoding in the status register
    typedef enum logic [2:0] {
        UIFL_PM_NONE = 3'h0,
        UIFL_PM_ODD  = 3'h1,
        UIFL_PM_EVEN = 3'h2,
        UIFL_PM_ONE  = 3'h3,
        UIFL_PM_ZERO = 3'h4
    } uifl_par_t;
    // axi responses
    localparam logic [1:0] UIFL_RESP_OKAY = 2'h0;
    localparam logic [1:0] UIFL_RESP_SLVERR = 2'h2;
endpackage

// ==== sim/uifl_host.sv ====
// axi4-lite host model that drives the register bus of the block
module uifl_host (
    // clock
    input wire logic aclk,
    // write address and data
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    // write response
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // read channels
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
    end
    // one write; address and data offered together, each held until taken
    task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp, output bit hung);
        int n;
        hung = 1'b1;
        resp = 2'h3;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64 && hung; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                hung = 1'b0;
            end
        end
        s_axi_bready <= 1'b0;
    endtask
    // one read; rready held until the data is seen
    task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp, output bit hung);
        int n;
        hung = 1'b1;
        d = '0;
        resp = 2'h3;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64 && hung; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                resp = s_axi_rresp;
                hung = 1'b0;
            end
        end
        s_axi_rready <= 1'b0;
    endtask
endmodule

// ==== sim/uifl_core_bench.sv ====
// self-checking bench for the interrupt identification and line format block
module uifl_core_bench;
    import uifl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // clock, reset and bus
    logic aclk, aresetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    // uart side and bookkeeping
    logic [UIFL_NCAUSE-1:0] cause_event;
    logic xon_received, tx_serial_in, tx_serial_out, divisor_access, irq;
    int num_errors, cmp_count;
    logic [31:0] seed;
    uifl_core u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cause_event, .xon_received,
        .tx_serial_in, .tx_serial_out, .divisor_access, .irq);
    uifl_host u_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // 25 ns clock
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // highest reported cause; levels 5 and 6 only with enhanced enable
    function automatic logic [31:0] exp_ident(input logic [6:0] p, input logic [1:0] cfg);
        logic [5:0] id;
        if (!cfg[UIFL_CFG_ENH]) p[6:5] = 2'b00;
        id = p[0] ? 6'h06 : p[1] ? 6'h04 : p[2] ? 6'h0c : p[3] ? 6'h02 : p[4] ? 6'h00 : p[5] ? 6'h10 :
            p[6] ? 6'h20 : 6'h01;
        return {24'h0, {2{cfg[UIFL_CFG_FIFO]}}, id};
    endfunction
    // decoded line format as the status register shows it
    function automatic logic [31:0] exp_status(input logic [7:0] v);
        logic [1:0] stop;
        logic [2:0] par;
        stop = !v[2] ? 2'h2 : (v[1:0] == 2'b00) ? 2'h3 : 2'h0;
        par = !v[3] ? 3'h0 : !v[4] ? (v[5] ? 3'h3 : 3'h1) : (v[5] ? 3'h4 : 3'h2);
        return {24'h0, par, stop, 1'b0, v[1:0]};
    endfunction
    task automatic complete_run();
        $display("errors %0d, comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // bus accesses; a lost answer ends the run
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] resp;
        bit hung;
        u_host.write(a, d, resp, hung);
        check({31'h0, hung}, 32'h0, "write answer");
        if (hung) complete_run();
        check({30'h0, resp}, {30'h0, er}, "write response");
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        logic [1:0] resp;
        bit hung;
        u_host.read(a, d, resp, hung);
        check({31'h0, hung}, 32'h0, "read answer");
        if (hung) complete_run();
        check({30'h0, resp}, {30'h0, er}, "read response");
    endtask
    // one-cycle cause and xon pulses, then settle
    task automatic pulse(input logic [6:0] ev, input logic xon);
        @(posedge aclk);
        cause_event <= ev;
        xon_received <= xon;
        @(posedge aclk);
        cause_event <= '0;
        xon_received <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    initial begin
        logic [31:0] rd, v;
        logic [6:0] ev, mk, svc;
        logic [1:0] cfg;
        int i;
        num_errors = 0;
        cmp_count = 0;
        seed = 32'h250c42dd;
        aresetn = 1'b0;
        cause_event = '0;
        xon_received = 1'b0;
        tx_serial_in = 1'b1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // defaults after reset
        reg_rd(UIFL_ADDR_IDENT, rd, UIFL_RESP_OKAY);
        check(rd, 32'h01, "ident after reset");
        reg_rd(UIFL_ADDR_LINE, rd, UIFL_RESP_OKAY);
        check(rd, 32'h0, "line after reset");
        check({31'h0, divisor_access}, 32'h0, "divisor access after reset");
        // every single cause, then random mixes, masks and modes
        for (i = 0; i < 47; i++) begin
            seed = lfsr(seed);
            ev = (i < 7) ? 7'h01 << i : seed[6:0] & 7'h5f;
            mk = (i < 27) ? 7'h7f : seed[13:7];
            cfg = (i < 7) ? 2'h3 : seed[15:14];
            reg_wr(UIFL_ADDR_MASK, {25'h0, mk}, UIFL_RESP_OKAY);
            reg_wr(UIFL_ADDR_CONFIG, {30'h0, cfg}, UIFL_RESP_OKAY);
            pulse(ev, 1'b0);
            check({31'h0, irq}, {31'h0, |(ev & mk)}, "irq level");
            reg_rd(UIFL_ADDR_IDENT, rd, UIFL_RESP_OKAY);
            check(rd, exp_ident(ev & mk, cfg), "ident code");
            pulse(7'h0, 1'b1);
            reg_wr(UIFL_ADDR_EVENTS, 32'h7f, UIFL_RESP_OKAY);
            reg_rd(UIFL_ADDR_IDENT, rd, UIFL_RESP_OKAY);
            check(rd, exp_ident(7'h0, cfg), "ident idle");
        end
        // lower causes appear only as higher ones are serviced
        reg_wr(UIFL_ADDR_MASK, 32'h7f, UIFL_RESP_OKAY);
        reg_wr(UIFL_ADDR_CONFIG, 32'h2, UIFL_RESP_OKAY);
        svc = 7'h0b;
        pulse(svc, 1'b0);
        for (i = 0; i < 4; i++) begin
            reg_rd(UIFL_ADDR_IDENT, rd, UIFL_RESP_OKAY);
            check(rd, exp_ident(svc, 2'h2), "ident while servicing");
            reg_wr(UIFL_ADDR_SERVICE, {25'h0, svc & (~svc + 7'h1)}, UIFL_RESP_OKAY);
            svc = svc & (svc - 7'h1);
        end
        // xoff hold survives clearing and drops on xon
        pulse(7'h20, 1'b0);
        reg_wr(UIFL_ADDR_EVENTS, 32'h7f, UIFL_RESP_OKAY);
        reg_rd(UIFL_ADDR_STATUS, rd, UIFL_RESP_OKAY);
        check({31'h0, rd[8]}, 32'h1, "xoff hold set");
        pulse(7'h0, 1'b1);
        reg_rd(UIFL_ADDR_STATUS, rd, UIFL_RESP_OKAY);
        check({31'h0, rd[8]}, 32'h0, "xoff hold released");
        // every parity code and word length, random stop, break and latch bits
        for (i = 0; i < 32; i++) begin
            seed = lfsr(seed);
            v = {24'h0, seed[7:6], i[2:0], seed[2], i[4:3]};
            tx_serial_in <= seed[8];
            reg_wr(UIFL_ADDR_LINE, v, UIFL_RESP_OKAY);
            reg_rd(UIFL_ADDR_LINE, rd, UIFL_RESP_OKAY);
            check(rd, v, "line readback");
            reg_rd(UIFL_ADDR_STATUS, rd, UIFL_RESP_OKAY);
            check({23'h0, rd[8:0]}, exp_status(v[7:0]), "format decode");
            check({31'h0, divisor_access}, {31'h0, v[7]}, "divisor access");
            check({31'h0, tx_serial_out}, {31'h0, seed[8] & ~v[6]}, "break output");
        end
        // unmapped place
        reg_rd(8'h1c, rd, UIFL_RESP_SLVERR);
        check(rd, 32'h0, "unmapped read data");
        reg_wr(8'h1c, 32'hff, UIFL_RESP_SLVERR);
        complete_run();
    end
endmodule
